// ---- pkg/pprs_pkg.sv ----
/*
  Shared constants and types for the phase-range selection servo block:
  register map, field layout, reference and speed-window counts, range modes.
  Assumes one core clock standing in for the crystal reference.
*/
// Operation
// R1: range_sel_hi/lo low/low is standard (2 pi), high/low is double (6 pi), high/high quadruple (14 pi), low/high test.
// R2: in standard range the phase output updates once per FG pulse.
// R3: double range updates once per two FG pulses, quadruple once per four.
// R4: with the FG divide-by-two on, every range updates at half the rate.
// R5: in double and quadruple ranges a limiter widens the span beyond two and four times standard.
// R6: double and quadruple ranges have hysteresis; standard has none.
// R7: phase difference is the FG phase measured against the internal reference.
// R8: the reference period is divider ratio times 2050 crystal cycles (1025 per raw FG with FG divider on).
// R9: three divider-select bits pick ratio 20, 10, 6, 3, 2 or 1 and whether the FG divider is on.
// R10: drive below lock minus 6%, brake above lock plus 6%, track with the phase output in between.
// R11: the test-mode select code is reserved and behaves as standard range.
package pprs_pkg;

  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] REG_PHASE = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int RANGE_LO_BIT = 0;
  localparam int RANGE_HI_BIT = 1;
  localparam int DIV_SEL_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam int REF_STEPS = 2050;
  localparam int HALF_STEPS = REF_STEPS / 2;
  localparam int SPEED_TOL_PCT = 6;
  localparam int PER_LO = (REF_STEPS * (100 - SPEED_TOL_PCT)) / 100;
  localparam int PER_HI = (REF_STEPS * (100 + SPEED_TOL_PCT) + 99) / 100;
  localparam int SPAN_STD = 1;
  localparam int SPAN_DBL = 3;
  localparam int SPAN_QUAD = 7;
  localparam int UPD_STD = 1;
  localparam int UPD_DBL = 2;
  localparam int UPD_QUAD = 4;
  localparam logic [7:0] CODE_FULL = 8'hff;
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam logic [7:0] CODE_MID = 8'h80;

  typedef enum logic [1:0] {PPRS_STD, PPRS_TEST, PPRS_DBL, PPRS_QUAD} pprs_range_t;
  typedef enum logic [1:0] {PPRS_DRIVE, PPRS_TRACK, PPRS_BRAKE} pprs_speed_t;

  typedef struct packed {
    logic [2:0] div_sel;
    logic range_sel_hi;
    logic range_sel_lo;
  } pprs_ctrl_t;

  typedef struct packed {
    logic [4:0] ratio;
    logic fg_div_on;
  } pprs_div_t;

  // divider-select decode
  function automatic pprs_div_t pprs_div_decode(input logic [2:0] sel);
    pprs_div_t d;
    d.fg_div_on = 1'b0;
    unique case (sel)
      3'h7: d.ratio = 5'd20;
      3'h6: d.ratio = 5'd10;
      3'h5: d.ratio = 5'd6;
      3'h4: d.ratio = 5'd3;
      3'h3: d.ratio = 5'd2;
      3'h2: d.ratio = 5'd1;
      3'h1: begin
        d.ratio = 5'd2;
        d.fg_div_on = 1'b1;
      end
      3'h0: begin
        d.ratio = 5'd1;
        d.fg_div_on = 1'b1;
      end
    endcase
    return d;
  endfunction : pprs_div_decode

endpackage : pprs_pkg

// ---- rtl/pprs_ref_gen.sv ----
/*
  Variable divider: one-cycle step pulse every ratio core cycles.
  Assumes ratio is at least 1; a ratio change keeps the count, which ends at once if already at or past the new ratio minus 1.
*/
`timescale 1ns/1ps
module pprs_ref_gen import pprs_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_ratio,
  output logic o_step
);
  logic [4:0] cnt;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt <= 5'h00;
      o_step <= 1'b0;
    end else if (cnt >= i_ratio - 5'd1) begin // [R8]
      cnt <= 5'h00;
      o_step <= 1'b1;
    end else begin
      cnt <= cnt + 5'd1;
      o_step <= 1'b0;
    end
  end

endmodule : pprs_ref_gen

// ---- rtl/pprs_top.sv ----
/*
  Phase-range selection servo core with an AXI4-Lite register slave.
  Tach pulses arrive asynchronously and are synchronised here.
  Assumes the core clock stands in for the crystal reference.
*/
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module pprs_top import pprs_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_tach_pulse_in,
  output logic [7:0] o_phase_ctrl_out,
  output logic o_lock,
  input wire logic [AXI_AW-1:0] i_s_awaddr,
  input wire logic i_s_awvalid,
  output logic o_s_awready,
  input wire logic [31:0] i_s_wdata,
  input wire logic [3:0] i_s_wstrb,
  input wire logic i_s_wvalid,
  output logic o_s_wready,
  output logic [1:0] o_s_bresp,
  output logic o_s_bvalid,
  input wire logic i_s_bready,
  input wire logic [AXI_AW-1:0] i_s_araddr,
  input wire logic i_s_arvalid,
  output logic o_s_arready,
  output logic [31:0] o_s_rdata,
  output logic [1:0] o_s_rresp,
  output logic o_s_rvalid,
  input wire logic i_s_rready
);
  pprs_ctrl_t ctrl;
  pprs_div_t div;
  pprs_range_t range_mode;
  pprs_speed_t speed;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic sync1, sync2, sync3;
  logic raw_edge, fg_half, fg_edge, step;
  logic [2:0] edge_cnt;
  logic [2:0] upd_need;
  logic [15:0] period;
  logic signed [15:0] acc, lim, next_acc;
  logic [7:0] phase_code;

  assign div = pprs_div_decode(ctrl.div_sel); // [R9]

  always_comb begin
    unique case ({ctrl.range_sel_hi, ctrl.range_sel_lo}) // [R1]
      2'b00: range_mode = PPRS_STD;
      2'b01: range_mode = PPRS_TEST;
      2'b10: range_mode = PPRS_DBL;
      2'b11: range_mode = PPRS_QUAD;
    endcase
  end

  // test code falls back to standard span and rate
  always_comb begin
    unique case (range_mode)
      PPRS_DBL: begin
        lim = 16'(SPAN_DBL * HALF_STEPS);
        upd_need = 3'(UPD_DBL); // [R3]
      end
      PPRS_QUAD: begin
        lim = 16'(SPAN_QUAD * HALF_STEPS);
        upd_need = 3'(UPD_QUAD); // [R3]
      end
      default: begin
        lim = 16'(SPAN_STD * HALF_STEPS); // [R11]
        upd_need = 3'(UPD_STD); // [R2]
      end
    endcase
  end

  pprs_ref_gen u_ref (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_ratio(div.ratio),
    .o_step(step)
  );

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= i_tach_pulse_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign raw_edge = sync2 & ~sync3;

  // fg divide-by-two keeps every other rising edge
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      fg_half <= 1'b0;
    end else if (raw_edge) begin
      fg_half <= ~fg_half;
    end
  end
  assign fg_edge = raw_edge & (~div.fg_div_on | fg_half); // [R4]

  // phase accumulator: fg edge adds a period, each reference step subtracts one
  always_comb begin
    next_acc = acc;
    if (fg_edge) begin
      next_acc = next_acc + 16'(REF_STEPS); // [R7]
    end
    if (step) begin
      next_acc = next_acc - 16'sd1;
    end
    if (range_mode == PPRS_DBL || range_mode == PPRS_QUAD) begin
      if (next_acc > lim) begin
        next_acc = lim; // [R5] [R6]
      end else if (next_acc < -lim) begin
        next_acc = -lim; // [R5] [R6]
      end
    end else if (next_acc >= lim) begin
      next_acc = next_acc - 16'(REF_STEPS);
    end else if (next_acc < -lim) begin
      next_acc = next_acc + 16'(REF_STEPS);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      acc <= 16'sh0000;
    end else begin
      acc <= next_acc;
    end
  end

  always_comb begin
    logic [31:0] scaled;
    scaled = 32'(32'(next_acc + lim) * 256) / 32'(2 * lim);
    phase_code = (scaled > 32'(CODE_FULL)) ? CODE_FULL : scaled[7:0];
  end

  // period between divided fg edges, in reference steps
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      period <= 16'h0000;
      speed <= PPRS_DRIVE;
    end else if (fg_edge) begin
      period <= 16'h0000;
      if (period > 16'(PER_HI)) begin
        speed <= PPRS_DRIVE; // [R10]
      end else if (period < 16'(PER_LO)) begin
        speed <= PPRS_BRAKE; // [R10]
      end else begin
        speed <= PPRS_TRACK; // [R10]
      end
    end else if (step && period <= 16'(PER_HI)) begin
      period <= period + 16'h0001;
    end else if (period > 16'(PER_HI)) begin
      speed <= PPRS_DRIVE; // [R10]
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      edge_cnt <= 3'h0;
      o_phase_ctrl_out <= CODE_FULL;
      o_lock <= 1'b0;
    end else begin
      o_lock <= (speed == PPRS_TRACK);
      if (speed == PPRS_DRIVE) begin
        o_phase_ctrl_out <= CODE_FULL; // [R10]
      end else if (speed == PPRS_BRAKE) begin
        o_phase_ctrl_out <= CODE_ZERO; // [R10]
      end
      if (fg_edge) begin
        if (edge_cnt + 3'h1 >= upd_need) begin
          edge_cnt <= 3'h0;
          if (speed == PPRS_TRACK) begin
            o_phase_ctrl_out <= phase_code; // [R2] [R3]
          end
        end else begin
          edge_cnt <= edge_cnt + 3'h1;
        end
      end
    end
  end

  // axi4-lite write: address and data in either order, response after both
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_s_awready <= 1'b1;
      o_s_wready <= 1'b1;
      o_s_bvalid <= 1'b0;
      o_s_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl <= pprs_ctrl_t'(CTRL_RESET[4:0]);
    end else begin
      if (i_s_awvalid && o_s_awready) begin
        aw_addr <= i_s_awaddr;
        o_s_awready <= 1'b0;
      end
      if (i_s_wvalid && o_s_wready) begin
        w_data <= i_s_wdata;
        w_strb <= i_s_wstrb;
        o_s_wready <= 1'b0;
      end
      if (!o_s_awready && !o_s_wready && !o_s_bvalid) begin
        o_s_bvalid <= 1'b1;
        if (aw_addr == REG_CTRL) begin
          o_s_bresp <= RESP_OKAY;
          if (w_strb[0]) begin
            ctrl.range_sel_lo <= w_data[RANGE_LO_BIT];
            ctrl.range_sel_hi <= w_data[RANGE_HI_BIT];
            ctrl.div_sel <= w_data[DIV_SEL_LSB +: 3];
          end
        end else if (aw_addr == REG_STATUS || aw_addr == REG_PHASE) begin
          o_s_bresp <= RESP_OKAY;
        end else begin
          o_s_bresp <= RESP_SLVERR;
        end
      end
      if (o_s_bvalid && i_s_bready) begin
        o_s_bvalid <= 1'b0;
        o_s_awready <= 1'b1;
        o_s_wready <= 1'b1;
      end
    end
  end

  // axi4-lite read: data registered one cycle after the address
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_s_arready <= 1'b1;
      o_s_rvalid <= 1'b0;
      o_s_rdata <= 32'h0000_0000;
      o_s_rresp <= RESP_OKAY;
    end else if (i_s_arvalid && o_s_arready) begin
      o_s_arready <= 1'b0;
      o_s_rvalid <= 1'b1;
      o_s_rresp <= RESP_OKAY;
      unique case (i_s_araddr)
        REG_CTRL: o_s_rdata <= {25'h0, ctrl.div_sel, 2'h0, ctrl.range_sel_hi, ctrl.range_sel_lo};
        REG_STATUS: o_s_rdata <= {21'h0, div.ratio, div.fg_div_on, range_mode, speed, o_lock};
        REG_PHASE: o_s_rdata <= {acc, 8'h00, o_phase_ctrl_out};
        default: begin
          o_s_rdata <= 32'h0000_0000;
          o_s_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (o_s_rvalid && i_s_rready) begin
      o_s_rvalid <= 1'b0;
      o_s_arready <= 1'b1;
    end
  end

  logic [4:0] step_gap;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      step_gap <= 5'h00;
    end else begin
      step_gap <= step ? 5'h00 : step_gap + 5'h01;
    end
  end

  // cycles since the divider ratio last changed, saturating
  logic [4:0] prev_ratio;
  logic [4:0] ratio_age;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      prev_ratio <= 5'h00;
      ratio_age <= 5'h00;
    end else begin
      prev_ratio <= div.ratio;
      if (div.ratio != prev_ratio) begin
        ratio_age <= 5'h00;
      end else if (ratio_age != 5'h1f) begin
        ratio_age <= ratio_age + 5'h01;
      end
    end
  end

  a_range_decode: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R1]
    ({ctrl.range_sel_hi, ctrl.range_sel_lo} == 2'b11) |-> (range_mode == PPRS_QUAD && lim == 16'(SPAN_QUAD * HALF_STEPS)))
    else $error("quadruple select not decoded");
  a_test_fallback: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R11]
    (range_mode == PPRS_TEST) |-> (upd_need == 3'(UPD_STD) && lim == 16'(HALF_STEPS)))
    else $error("test code not treated as standard");
  a_std_update: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R2]
    (range_mode == PPRS_STD && fg_edge && speed == PPRS_TRACK) |=> (o_phase_ctrl_out == $past(phase_code)))
    else $error("standard range missed an update");
  a_wide_hold: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R3]
    (fg_edge && edge_cnt + 3'h1 < upd_need && speed == PPRS_TRACK && $stable(speed)) |=>
      $stable(o_phase_ctrl_out) && edge_cnt == $past(edge_cnt) + 3'h1)
    else $error("wide range updated too often");
  a_fgdiv_half: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R4]
    (div.fg_div_on && raw_edge && !fg_half) |-> !fg_edge ##1 fg_half)
    else $error("fg divider passed a skipped edge");
  a_limit_span: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R5]
    (range_mode == PPRS_QUAD && $stable(range_mode)) |-> (acc <= lim && acc >= -lim))
    else $error("phase beyond quadruple span");
  a_sat_hold: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R6]
    (range_mode == PPRS_DBL && acc == lim && fg_edge) |=> (acc == lim))
    else $error("double range saturation lost");
  a_fg_direction: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R7]
    (range_mode == PPRS_QUAD && fg_edge && acc <= lim - 16'(REF_STEPS)) |=>
      (acc == $past(acc) + 16'(REF_STEPS) - ($past(step) ? 16'sd1 : 16'sd0)))
    else $error("fg edge did not advance phase");
  a_step_spacing: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R8]
    (step && ratio_age == 5'h1f) |-> (step_gap == div.ratio - 5'd1))
    else $error("reference step spacing wrong");
  a_div_table: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R9]
    (ctrl.div_sel == 3'h7) |-> (div.ratio == 5'd20 && !div.fg_div_on))
    else $error("divider select 7 not ratio 20");
  a_drive_out: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R10]
    (fg_edge && period > 16'(PER_HI)) |-> ##2 (o_phase_ctrl_out == CODE_FULL && !o_lock))
    else $error("underspeed did not drive");

endmodule : pprs_top

// ---- tb/pprs_tach_model.sv ----
/*
  Tachometer stand-in: square pulse train of a programmable period in core cycles.
  Assumes the period is read at each rising edge for the high half and at each falling edge for the low half; the line rests low when stopped.
*/
`timescale 1ns/1ps
module pprs_tach_model (
  input wire logic i_core_clk,
  input wire logic i_run,
  input wire logic [15:0] i_period,
  output logic o_tach_pulse
);
  initial begin
    o_tach_pulse = 1'b0;
    forever begin
      @(posedge i_core_clk);
      if (i_run) begin
        o_tach_pulse <= 1'b1;
        repeat (i_period / 2) @(posedge i_core_clk);
        o_tach_pulse <= 1'b0;
        repeat (i_period - i_period / 2 - 1) @(posedge i_core_clk);
      end
    end
  end
endmodule : pprs_tach_model

// ---- tb/pprs_top_test.sv ----
/*
  Self-checking bench for the phase-range servo core: register access, divider decode,
  update rates per range, speed window. Assumes the tach model and an AXI4-Lite master here.
*/
`timescale 1ns/1ps
module pprs_top_test import pprs_pkg::*; ;
  logic core_clk;
  logic reset;
  logic tach;
  logic run;
  logic [15:0] period;
  logic [7:0] phase_code;
  logic lock;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  logic counting;
  logic [7:0] prev_code;
  int changes, n;
  int cycles = 0;
  int bad_count = 0;
  int total_checks = 0;

  pprs_top pprs_top_i (.i_core_clk(core_clk), .i_reset(reset), .i_tach_pulse_in(tach),
    .o_phase_ctrl_out(phase_code), .o_lock(lock), .i_s_awaddr(awaddr), .i_s_awvalid(awvalid),
    .o_s_awready(awready), .i_s_wdata(wdata), .i_s_wstrb(wstrb), .i_s_wvalid(wvalid),
    .o_s_wready(wready), .o_s_bresp(bresp), .o_s_bvalid(bvalid), .i_s_bready(bready),
    .i_s_araddr(araddr), .i_s_arvalid(arvalid), .o_s_arready(arready), .o_s_rdata(rdata),
    .o_s_rresp(rresp), .o_s_rvalid(rvalid), .i_s_rready(rready));

  pprs_tach_model pprs_tach_model_i (.i_core_clk(core_clk), .i_run(run), .i_period(period),
    .o_tach_pulse(tach));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      bad_count++;
      end_sim();
    end
  end

  // counts output code changes inside a measuring window
  always @(posedge core_clk) begin
    if (counting && phase_code !== prev_code) changes <= changes + 1;
    prev_code <= phase_code;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    resp = rresp;
  endtask : axi_rd

  task automatic reg_access();
    logic [31:0] s;
    axi_rd(REG_CTRL, d, r);
    check(d, 32'h0);
    axi_wr(8'h0c, 32'h33, r);
    check(r, RESP_SLVERR);
    axi_rd(8'h0c, d, r);
    check(d, 32'h0);
    check(r, RESP_SLVERR);
    axi_rd(REG_STATUS, s, r);
    check(s[10:5], {5'd1, 1'b1});
    axi_wr(REG_STATUS, 32'hffffffff, r);
    check(r, RESP_OKAY);
    axi_rd(REG_STATUS, d, r);
    check(d, s);
  endtask : reg_access

  task automatic div_table();
    logic [39:0] tab;
    tab = {5'd20, 5'd10, 5'd6, 5'd3, 5'd2, 5'd1, 5'd2, 5'd1};
    for (int i = 0; i < 8; i++) begin
      axi_wr(REG_CTRL, 32'(i) << DIV_SEL_LSB, r);
      axi_rd(REG_STATUS, d, r);
      check(d[10:5], {tab[i*5 +: 5], i < 2});
    end
  endtask : div_table

  // drifts the phase toward zero so the limited ranges never clamp
  task automatic upd_count(input logic [1:0] rng, input logic [2:0] dsel, input logic fgd, output int cnt);
    int p;
    axi_wr(REG_CTRL, {25'h0, dsel, 2'h0, rng}, r);
    axi_rd(REG_PHASE, d, r);
    p = d[31] ? 2000 : 2100;
    period <= fgd ? 16'(p / 2) : 16'(p);
    repeat (fgd ? 4 : 2) @(posedge tach);
    repeat (8) @(posedge core_clk);
    check(lock, 1'b1);
    axi_rd(REG_STATUS, d, r);
    check(d[4:3], rng);
    changes <= 0;
    counting <= 1'b1;
    repeat (4) @(posedge tach);
    repeat (8) @(posedge core_clk);
    counting <= 1'b0;
    @(posedge core_clk);
    cnt = changes;
  endtask : upd_count

  task automatic speed_limits();
    axi_wr(REG_CTRL, 32'h20, r);
    period <= 16'd1800;
    repeat (4) @(posedge tach);
    repeat (8) @(posedge core_clk);
    check(phase_code, 8'h00);
    check(lock, 1'b0);
    run <= 1'b0;
    repeat (2400) @(posedge core_clk);
    check(phase_code, 8'hff);
  endtask : speed_limits

  initial begin
    reset = 1'b1;
    run = 1'b0;
    period = 16'd2050;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    counting = 1'b0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check(phase_code, 8'hff);
    check(lock, 1'b0);
    reg_access();
    div_table();
    run <= 1'b1;
    repeat (3) @(posedge tach);
    upd_count(2'h0, 3'h2, 1'b0, n);
    check(n, 4);
    upd_count(2'h1, 3'h2, 1'b0, n);
    check(n, 4);
    upd_count(2'h2, 3'h2, 1'b0, n);
    check(n, 2);
    upd_count(2'h3, 3'h2, 1'b0, n);
    check(n, 1);
    upd_count(2'h2, 3'h0, 1'b1, n);
    check(n, 1);
    speed_limits();
    end_sim();
  end
endmodule : pprs_top_test
